// File: e1b_pkg.sv
// constants, types and helper functions of the e1 configuration bank
// assumes a single 50 MHz clock and byte-wide register access by index
package e1b_pkg;

    // ------------------------------------------------------------
    // clock and reset timing
    // ------------------------------------------------------------
    localparam int E1B_CLK_MHZ = 50;
    localparam int E1B_RESET_MIN_US = 10;
    localparam int E1B_RESET_MIN_CYC = E1B_RESET_MIN_US * E1B_CLK_MHZ;
    localparam int E1B_RST_CNT_W = 10;

    // ------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------
    localparam int E1B_NREG = 59;
    localparam int E1B_ADDR_W = 7;
    localparam logic [6:0] E1B_IDX_LOOP_CTRL = 7'h00;
    localparam logic [6:0] E1B_IDX_TX_SERVICE_WORD = 7'h01;
    localparam logic [6:0] E1B_IDX_TX_SPARE_BITS = 7'h02;
    localparam logic [6:0] E1B_IDX_TRANSPARENT_MODE = 7'h03;
    localparam logic [6:0] E1B_IDX_TX_CLOCK_OFFSET = 7'h04;
    localparam logic [6:0] E1B_IDX_TX_SLOT_OFFSET = 7'h05;
    localparam logic [6:0] E1B_IDX_RX_CLOCK_OFFSET = 7'h06;
    localparam logic [6:0] E1B_IDX_RX_SLOT_OFFSET = 7'h07;
    localparam logic [6:0] E1B_IDX_IDLE_CODE = 7'h08;
    localparam logic [6:0] E1B_IDX_IDLE_SEL0 = 7'h09;
    localparam logic [6:0] E1B_IDX_LINE_IF_A = 7'h0D;
    localparam logic [6:0] E1B_IDX_LINE_IF_B = 7'h0E;
    localparam logic [6:0] E1B_IDX_LOS_DETECT = 7'h0F;
    localparam logic [6:0] E1B_IDX_LOS_RECOVER = 7'h10;
    localparam logic [6:0] E1B_IDX_TX_PULSE0 = 7'h11;
    localparam logic [6:0] E1B_IDX_INT_MASK0 = 7'h14;
    localparam logic [6:0] E1B_IDX_RX_SLOT_SEL0 = 7'h1A;
    localparam logic [6:0] E1B_IDX_TX_SLOT_SEL0 = 7'h1E;
    localparam logic [6:0] E1B_IDX_EXTRA_SLOT_A = 7'h22;
    localparam logic [6:0] E1B_IDX_EXTRA_SLOT_B = 7'h23;
    localparam logic [6:0] E1B_IDX_GLOBAL_CONFIG = 7'h24;
    localparam logic [6:0] E1B_IDX_CLOCK_MODE_A = 7'h25;
    localparam logic [6:0] E1B_IDX_CLOCK_MODE_B = 7'h26;
    localparam logic [6:0] E1B_IDX_PORT_CONFIG0 = 7'h27;
    localparam logic [6:0] E1B_IDX_SIG_MODE_A = 7'h2D;
    localparam logic [6:0] E1B_IDX_SIG_MODE_B = 7'h2E;
    localparam logic [6:0] E1B_IDX_SIG_MODE_C = 7'h2F;
    localparam logic [6:0] E1B_IDX_ADDR_CMP_HIGH0 = 7'h30;
    localparam logic [6:0] E1B_IDX_ADDR_CMP_LOW0 = 7'h32;
    localparam logic [6:0] E1B_IDX_GLOBAL_CLOCK0 = 7'h34;
    localparam logic [6:0] E1B_IDX_FRAMER_MODE = 7'h3A;
    localparam int E1B_PROTOCOL_SELECT_BIT = 0;

    // write-only indices
    localparam logic [6:0] E1B_IDX_TX_FIFO = 7'h40;
    localparam logic [6:0] E1B_IDX_TX_SIGNALING0 = 7'h41;
    localparam logic [6:0] E1B_IDX_COMMAND = 7'h51;
    localparam logic [6:0] E1B_IDX_DECREMENT = 7'h52;

    // ------------------------------------------------------------
    // reset values that are not zero
    // ------------------------------------------------------------
    localparam logic [7:0] E1B_RST_SLOT_OFFSET = 8'h9C;
    localparam logic [7:0] E1B_RST_TX_PULSE0 = 8'h40;
    localparam logic [7:0] E1B_RST_TX_PULSE1 = 8'h03;
    localparam logic [7:0] E1B_RST_TX_PULSE2 = 8'h7B;
    localparam logic [7:0] E1B_RST_INT_MASK = 8'hFF;
    localparam logic [7:0] E1B_RST_ADDR_CMP_HIGH0 = 8'hFD;
    localparam logic [7:0] E1B_RST_ADDR_CMP_OTHER = 8'hFF;
    localparam int E1B_INT_MASK_N = 6;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef logic [E1B_NREG-1:0][7:0] e1b_bank_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [7:0] data;
    } e1b_req_t;

    typedef struct packed {
        logic strobe;
        logic [6:0] index;
        logic [7:0] data;
    } e1b_wo_t;

    typedef struct packed {
        e1b_bank_t bank;
        logic rd_valid;
        logic [7:0] rd_data;
        e1b_wo_t wo;
        logic t1_mode;
    } e1b_state_t;

    typedef struct packed {
        logic [E1B_RST_CNT_W-1:0] count;
        logic hold;
    } e1b_rq_state_t;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic e1b_bank_t e1b_default_bank();
        e1b_bank_t b;
        b = '0;
        b[E1B_IDX_TX_SLOT_OFFSET] = E1B_RST_SLOT_OFFSET;
        b[E1B_IDX_RX_SLOT_OFFSET] = E1B_RST_SLOT_OFFSET;
        b[E1B_IDX_TX_PULSE0] = E1B_RST_TX_PULSE0;
        b[E1B_IDX_TX_PULSE0 + 7'h01] = E1B_RST_TX_PULSE1;
        b[E1B_IDX_TX_PULSE0 + 7'h02] = E1B_RST_TX_PULSE2;
        for (int i = 0; i < E1B_INT_MASK_N; i++) begin
            b[E1B_IDX_INT_MASK0 + 7'(i)] = E1B_RST_INT_MASK;
        end
        b[E1B_IDX_ADDR_CMP_HIGH0] = E1B_RST_ADDR_CMP_HIGH0;
        b[E1B_IDX_ADDR_CMP_HIGH0 + 7'h01] = E1B_RST_ADDR_CMP_OTHER;
        b[E1B_IDX_ADDR_CMP_LOW0] = E1B_RST_ADDR_CMP_OTHER;
        b[E1B_IDX_ADDR_CMP_LOW0 + 7'h01] = E1B_RST_ADDR_CMP_OTHER;
        return b;
    endfunction : e1b_default_bank

    function automatic logic e1b_is_bank(logic [6:0] a);
        return a < 7'(E1B_NREG);
    endfunction : e1b_is_bank

    function automatic logic e1b_is_write_only(logic [6:0] a);
        return (a >= E1B_IDX_TX_FIFO) && (a <= E1B_IDX_DECREMENT);
    endfunction : e1b_is_write_only

endpackage : e1b_pkg

// File: e1b_reset_qual.sv
// qualifies the active-low reset pin by its minimum low time
// assumes the pin is synchronous to clock
module e1b_reset_qual
    import e1b_pkg::*;
#(
    parameter int MIN_CYC = E1B_RESET_MIN_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic reset_pin_n,
    output logic hold
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    e1b_rq_state_t st_reg;
    e1b_rq_state_t st_next;

    // short glitches must not wipe the bank, so the low time is counted first
    always_comb begin
        st_next = st_reg;
        if (reset_pin_n) begin
            st_next.count = '0;
            st_next.hold = 1'b0;
        end else if (st_reg.count != E1B_RST_CNT_W'(MIN_CYC)) begin
            st_next.count = st_reg.count + 1'b1;
            st_next.hold = (st_reg.count == E1B_RST_CNT_W'(MIN_CYC - 1));
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hold = st_reg.hold;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    hold_min_low_a: assert property (@(posedge clock) disable iff (rst)
        $rose(st_reg.hold) |-> st_reg.count == E1B_RST_CNT_W'(MIN_CYC) && $past(!reset_pin_n))
        else $error("reset hold rose before the minimum low time");

    hold_release_a: assert property (@(posedge clock) disable iff (rst)
        reset_pin_n |=> !st_reg.hold && st_reg.count == '0)
        else $error("reset hold stayed after the pin went high");

endmodule : e1b_reset_qual

// File: e1b_config_bank.sv
// configuration register bank of the e1 framer with its reset defaults
// assumes byte access by register index, synchronous to clock
//
// Functional notes
// - loop control register resets to 00
// - service word, spare bits and transparent mode registers reset to 00
// - transmit clock offset resets to 00, transmit slot offset to 9C
// - receive clock offset resets to 00, receive slot offset to 9C
// - idle code and four idle channel selects reset to zero
// - both line interface mode registers reset to 00
// - loss-of-signal detect and recover pulse counts reset to 00
// - three transmit pulse shape registers reset to 40, 03, 7B
// - all six interrupt masks reset to FF
// - receive, transmit and extra slot selects reset to zero
// - global config resets to 00
// - first clock mode register resets to 00
// - second clock mode register resets to 00
// - first four port config registers reset to zero
// - fifth and sixth port config registers reset to zero
// - three signaling mode registers reset to 00
// - address compare high resets FD, FF; low resets FF, FF
// - six global clock mode registers reset to zero
// - protocol select bit set switches the device to t1 operation
// - control registers read and write, except fifo, signaling, command, decrement
// - reset pin low at least 10 us resets, leaving e1 operation
module e1b_config_bank
    import e1b_pkg::*;
#(
    parameter int RESET_MIN_CYC = E1B_RESET_MIN_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic reset_pin_n,
    input wire e1b_req_t req,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output e1b_wo_t wo,
    output e1b_bank_t bank,
    output logic t1_mode,
    output logic in_reset
);

    // ------------------------------------------------------------
    // reset pin qualification
    // ------------------------------------------------------------
    logic hold;

    e1b_reset_qual #(
        .MIN_CYC(RESET_MIN_CYC)
    ) u_reset_qual (
        .clock(clock),
        .rst(rst),
        .reset_pin_n(reset_pin_n),
        .hold(hold)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    e1b_state_t st_reg;
    e1b_state_t st_next;

    // one constant image, so the reset branch loads plain constants
    localparam e1b_bank_t DEFAULT_BANK = e1b_default_bank();

    // requests are dropped while hold is high; the bank is held at defaults
    always_comb begin
        st_next = st_reg;
        st_next.rd_valid = 1'b0;
        st_next.wo.strobe = 1'b0;
        if (hold) begin
            st_next.bank = DEFAULT_BANK;
            st_next.rd_data = 8'h00;
        end else begin
            if (req.rd) begin
                st_next.rd_valid = 1'b1;
                // write-only and unused indices read as zero
                st_next.rd_data = e1b_is_bank(req.addr) ? st_reg.bank[req.addr] : 8'h00;
            end
            if (req.wr) begin
                if (e1b_is_bank(req.addr)) begin
                    st_next.bank[req.addr] = req.data;
                end else if (e1b_is_write_only(req.addr)) begin
                    // write-only targets only pass the byte on, nothing is stored
                    st_next.wo.strobe = 1'b1;
                    st_next.wo.index = req.addr;
                    st_next.wo.data = req.data;
                end
            end
        end
        // protocol select steers the operating mode
        st_next.t1_mode = st_next.bank[E1B_IDX_FRAMER_MODE][E1B_PROTOCOL_SELECT_BIT];
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.bank <= DEFAULT_BANK;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rd_valid = st_reg.rd_valid;
    assign rd_data = st_reg.rd_data;
    assign wo = st_reg.wo;
    assign bank = st_reg.bank;
    assign t1_mode = st_reg.t1_mode;
    assign in_reset = hold;

    // ------------------------------------------------------------
    // check helpers
    // ------------------------------------------------------------
    // true when n registers from index first on all hold v
    function automatic logic span_is(e1b_bank_t b, int first, int n, logic [7:0] v);
        logic ok;
        ok = 1'b1;
        for (int i = first; i < first + n; i++) begin
            ok = ok && (b[i] == v);
        end
        return ok;
    endfunction : span_is

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    all_defaults_a: assert property ($fell(hold) |-> st_reg.bank == e1b_default_bank())
        else $error("bank not at defaults when reset released");

    loop_service_a: assert property (hold |=> st_reg.bank[E1B_IDX_LOOP_CTRL] == 8'h00
        && st_reg.bank[E1B_IDX_TX_SERVICE_WORD] == 8'h00
        && st_reg.bank[E1B_IDX_TX_SPARE_BITS] == 8'h00
        && st_reg.bank[E1B_IDX_TRANSPARENT_MODE] == 8'h00)
        else $error("loop or service word default wrong");

    offset_defaults_a: assert property (hold |=> st_reg.bank[E1B_IDX_TX_CLOCK_OFFSET] == 8'h00
        && st_reg.bank[E1B_IDX_TX_SLOT_OFFSET] == 8'h9C
        && st_reg.bank[E1B_IDX_RX_CLOCK_OFFSET] == 8'h00
        && st_reg.bank[E1B_IDX_RX_SLOT_OFFSET] == 8'h9C)
        else $error("offset default wrong");

    pulse_shape_a: assert property (hold |=> st_reg.bank[E1B_IDX_TX_PULSE0] == 8'h40
        && st_reg.bank[E1B_IDX_TX_PULSE0 + 7'h01] == 8'h03
        && st_reg.bank[E1B_IDX_TX_PULSE0 + 7'h02] == 8'h7B)
        else $error("pulse shape default wrong");

    int_mask_a: assert property (hold |=> st_reg.bank[E1B_IDX_INT_MASK0] == 8'hFF
        && st_reg.bank[E1B_IDX_INT_MASK0 + 7'h05] == 8'hFF)
        else $error("interrupt mask default wrong");

    addr_compare_a: assert property (hold |=> st_reg.bank[E1B_IDX_ADDR_CMP_HIGH0] == 8'hFD
        && st_reg.bank[E1B_IDX_ADDR_CMP_HIGH0 + 7'h01] == 8'hFF
        && st_reg.bank[E1B_IDX_ADDR_CMP_LOW0 + 7'h01] == 8'hFF)
        else $error("address compare default wrong");

    clock_mode_a: assert property (hold |=> st_reg.bank[E1B_IDX_CLOCK_MODE_A] == 8'h00
        && st_reg.bank[E1B_IDX_CLOCK_MODE_B] == 8'h00
        && st_reg.bank[E1B_IDX_GLOBAL_CLOCK0 + 7'h05] == 8'h00 && !st_reg.t1_mode)
        else $error("clock mode default or e1 mode wrong");

    write_only_read_a: assert property (req.rd && !hold && !e1b_is_bank(req.addr)
        |=> st_reg.rd_valid && st_reg.rd_data == 8'h00)
        else $error("write-only or unused index read not zero");

    write_read_back_a: assert property (req.wr && !hold && e1b_is_bank(req.addr) ##1
        !req.wr && !hold ##1
        (req.rd && !req.wr && !hold && req.addr == $past(req.addr, 2))
        |=> st_reg.rd_valid && st_reg.rd_data == $past(req.data, 3))
        else $error("control register did not read back");

    write_only_strobe_a: assert property (req.wr && !hold && e1b_is_write_only(req.addr)
        |=> st_reg.wo.strobe && st_reg.wo.index == $past(req.addr)
            && st_reg.wo.data == $past(req.data))
        else $error("write-only strobe missing");

    protocol_mode_a: assert property (st_reg.t1_mode
        == st_reg.bank[E1B_IDX_FRAMER_MODE][E1B_PROTOCOL_SELECT_BIT])
        else $error("t1 mode does not follow protocol select");

    // ------------------------------------------------------------
    // remaining reset defaults, held while the pin reset lasts
    // ------------------------------------------------------------
    idle_dflt_a: assert property (hold |=>
        span_is(st_reg.bank, E1B_IDX_IDLE_CODE, 5, 8'h00))
        else $error("idle code or idle select default wrong");

    line_if_dflt_a: assert property (hold |=>
        span_is(st_reg.bank, E1B_IDX_LINE_IF_A, 2, 8'h00))
        else $error("line interface mode default wrong");

    los_count_dflt_a: assert property (hold |=>
        span_is(st_reg.bank, E1B_IDX_LOS_DETECT, 2, 8'h00))
        else $error("loss-of-signal pulse count default wrong");

    int_mask_all_a: assert property (hold |=>
        span_is(st_reg.bank, E1B_IDX_INT_MASK0, E1B_INT_MASK_N, E1B_RST_INT_MASK))
        else $error("one of the interrupt masks not set");

    slot_sel_dflt_a: assert property (hold |=>
        span_is(st_reg.bank, E1B_IDX_RX_SLOT_SEL0, 10, 8'h00))
        else $error("time slot select default wrong");

    global_cfg_dflt_a: assert property (hold |=>
        span_is(st_reg.bank, E1B_IDX_GLOBAL_CONFIG, 1, 8'h00))
        else $error("global config default wrong");

    clock_mode_b_a: assert property (hold |=>
        span_is(st_reg.bank, E1B_IDX_CLOCK_MODE_B, 1, 8'h00))
        else $error("second clock mode default wrong");

    port_low_dflt_a: assert property (hold |=>
        span_is(st_reg.bank, E1B_IDX_PORT_CONFIG0, 4, 8'h00))
        else $error("first four port configs not zero");

    port_high_dflt_a: assert property (hold |=>
        span_is(st_reg.bank, E1B_IDX_PORT_CONFIG0 + 7'h04, 2, 8'h00))
        else $error("fifth or sixth port config not zero");

    sig_mode_dflt_a: assert property (hold |=>
        span_is(st_reg.bank, E1B_IDX_SIG_MODE_A, 3, 8'h00))
        else $error("signaling mode default wrong");

    addr_low_dflt_a: assert property (hold |=>
        span_is(st_reg.bank, E1B_IDX_ADDR_CMP_LOW0, 2, E1B_RST_ADDR_CMP_OTHER))
        else $error("low address compare default wrong");

    global_clock_dflt_a: assert property (hold |=>
        span_is(st_reg.bank, E1B_IDX_GLOBAL_CLOCK0, 6, 8'h00))
        else $error("global clock mode default wrong");

    e1_after_hold_a: assert property (hold |=>
        !st_reg.t1_mode)
        else $error("pin reset did not leave e1 operation");

    // ------------------------------------------------------------
    // access checks
    // ------------------------------------------------------------
    // a request during pin reset must leave no trace at all
    hold_refuse_a: assert property (hold |=>
        !st_reg.rd_valid && !st_reg.wo.strobe && st_reg.rd_data == 8'h00)
        else $error("request answered during pin reset");

    refuse_write_a: assert property (hold && req.wr && e1b_is_bank(req.addr) |=>
        st_reg.bank[$past(req.addr)] == DEFAULT_BANK[$past(req.addr)])
        else $error("write landed during pin reset");

    write_store_a: assert property (req.wr && !hold && e1b_is_bank(req.addr) |=>
        st_reg.bank[$past(req.addr)] == $past(req.data))
        else $error("control register write not stored");

    strobe_cause_a: assert property (st_reg.wo.strobe |->
        $past(req.wr && !hold && e1b_is_write_only(req.addr)))
        else $error("write-only strobe without a write");

    read_cause_a: assert property (st_reg.rd_valid |->
        $past(req.rd && !hold))
        else $error("read answer without a read");

    bank_quiet_a: assert property (!req.wr && !hold |=>
        $stable(st_reg.bank))
        else $error("bank changed without a write");

    rd_data_stable_a: assert property (!req.rd && !hold |=>
        $stable(st_reg.rd_data))
        else $error("read data changed without a read");

    wo_stable_a: assert property (!(req.wr && !hold && e1b_is_write_only(req.addr)) |=>
        $stable(st_reg.wo.index) && $stable(st_reg.wo.data))
        else $error("write-only byte changed without a write");

    t1_follow_a: assert property (req.wr && !hold && req.addr == E1B_IDX_FRAMER_MODE |=>
        st_reg.t1_mode == $past(req.data[E1B_PROTOCOL_SELECT_BIT]))
        else $error("protocol select write did not steer the mode");

    // ------------------------------------------------------------
    // coverage
    // ------------------------------------------------------------
    reset_release_cv: cover property ($fell(hold) ##1 st_reg.rd_valid);
    write_only_cv: cover property (st_reg.wo.strobe && st_reg.wo.index == E1B_IDX_COMMAND);
    t1_enter_cv: cover property ($rose(st_reg.t1_mode));
    readback_cv: cover property (st_reg.rd_valid && st_reg.rd_data == 8'h9C);
    pin_reset_cv: cover property ($rose(hold));

endmodule : e1b_config_bank

// File: e1b_config_bank_test.sv
// self-checking bench of the e1 configuration bank: defaults, access, pin reset
// assumes the bank alone, requests driven as a struct, pin reset qualified over 4 cycles
`define CHK(nm, exp, got) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("Error %s expected %h seen %h", nm, exp, got); \
    end \
end

module e1_reset_defaults_config_bank_test import e1b_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    // short qualify count keeps the run brief; expectations follow it
    localparam int MINC = 4;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic reset_pin_n = 1'b1;
    e1b_req_t req = '0;
    logic rd_valid;
    logic [7:0] rd_data;
    e1b_wo_t wo;
    e1b_bank_t bank;
    logic t1_mode;
    logic in_reset;
    int error_cnt = 0;
    int samples_checked = 0;
    logic [31:0] seed = 32'h0BB02B0B;
    logic [31:0] r;
    logic [6:0] a;
    logic [7:0] model [0:E1B_NREG-1];

    always #10 clock = ~clock;

    e1b_config_bank #(.RESET_MIN_CYC(MINC)) dut (
        .clock(clock),
        .rst(rst),
        .reset_pin_n(reset_pin_n),
        .req(req),
        .rd_valid(rd_valid),
        .rd_data(rd_data),
        .wo(wo),
        .bank(bank),
        .t1_mode(t1_mode),
        .in_reset(in_reset)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] dflt(input int i);
        if (i == 5 || i == 7) return 8'h9C;
        if (i == 17) return 8'h40;
        if (i == 18) return 8'h03;
        if (i == 19) return 8'h7B;
        if (i >= 20 && i <= 25) return 8'hFF;
        if (i == 48) return 8'hFD;
        if (i >= 49 && i <= 51) return 8'hFF;
        return 8'h00;
    endfunction : dflt

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // request held for exactly one taking edge, then released
    task automatic access(input logic w, input logic rq, input logic [6:0] ad,
                          input logic [7:0] d);
        @(posedge clock);
        req <= '{wr: w, rd: rq, addr: ad, data: d};
        @(posedge clock);
        req <= '0;
        #1;
    endtask : access

    task automatic rd_chk(input logic [6:0] ad, input logic [7:0] e);
        access(1'b0, 1'b1, ad, 8'h00);
        `CHK("rd_valid", 1'b1, rd_valid)
        `CHK("rd_data", e, rd_data)
    endtask : rd_chk

    task automatic load_dflt();
        for (int i = 0; i < E1B_NREG; i++) model[i] = dflt(i);
    endtask : load_dflt

    task automatic chk_bank();
        for (int i = 0; i < E1B_NREG; i++) `CHK("bank", model[i], bank[i])
    endtask : chk_bank

    task automatic chk_all_rd();
        for (int i = 0; i < E1B_NREG; i++) rd_chk(7'(i), model[i]);
    endtask : chk_all_rd

    task automatic finish_test();
        $display("errors %0d of %0d checks", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        load_dflt();
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        #1;
        chk_bank();
        `CHK("t1_mode", 1'b0, t1_mode)
        chk_all_rd();
        for (int n = 0; n < 300; n++) begin
            r = xs();
            a = 7'(r[15:8] % E1B_NREG);
            if (r[0]) begin
                access(1'b1, 1'b0, a, r[23:16]);
                model[a] = r[23:16];
            end else begin
                rd_chk(a, model[a]);
            end
            `CHK("t1_mode", model[58][0], t1_mode)
        end
        chk_bank();
        access(1'b1, 1'b0, 7'h3A, 8'h01);
        `CHK("t1_mode", 1'b1, t1_mode)
        access(1'b1, 1'b0, 7'h3A, 8'h00);
        `CHK("t1_mode", 1'b0, t1_mode)
        model[58] = 8'h00;
        // same-cycle write and read must answer the old value
        access(1'b1, 1'b1, 7'h24, 8'hA5);
        `CHK("collide", model[36], rd_data)
        model[36] = 8'hA5;
        rd_chk(7'h24, 8'hA5);
        for (int i = 64; i <= 82; i++) begin
            r = xs();
            access(1'b1, 1'b0, 7'(i), r[7:0]);
            `CHK("wo_strobe", 1'b1, wo.strobe)
            `CHK("wo_index", 7'(i), wo.index)
            `CHK("wo_data", r[7:0], wo.data)
            rd_chk(7'(i), 8'h00);
        end
        access(1'b1, 1'b0, 7'h3B, 8'h00);
        access(1'b1, 1'b0, 7'h7F, 8'h00);
        rd_chk(7'h3B, 8'h00);
        chk_bank();
        // a pin pulse one cycle short of the minimum must not reset
        @(posedge clock);
        reset_pin_n <= 1'b0;
        repeat (MINC - 1) @(posedge clock);
        reset_pin_n <= 1'b1;
        @(posedge clock);
        #1;
        `CHK("in_reset", 1'b0, in_reset)
        chk_bank();
        @(posedge clock);
        reset_pin_n <= 1'b0;
        repeat (MINC + 2) @(posedge clock);
        #1;
        `CHK("in_reset", 1'b1, in_reset)
        access(1'b1, 1'b1, 7'h00, 8'hFF);
        `CHK("rd_valid", 1'b0, rd_valid)
        load_dflt();
        chk_bank();
        @(posedge clock);
        reset_pin_n <= 1'b1;
        @(posedge clock);
        #1;
        `CHK("in_reset", 1'b0, in_reset)
        chk_all_rd();
        access(1'b1, 1'b0, 7'h14, 8'h00);
        @(posedge clock);
        rst <= 1'b1;
        #1;
        chk_bank();
        @(posedge clock);
        rst <= 1'b0;
        rd_chk(7'h14, 8'hFF);
        // host set-up after reset: basic, then operational, then optional
        access(1'b1, 1'b0, 7'h34, 8'h00);
        access(1'b1, 1'b0, 7'h3A, 8'h00);
        access(1'b1, 1'b0, 7'h0D, 8'h12);
        access(1'b1, 1'b0, 7'h2D, 8'h88);
        access(1'b1, 1'b0, 7'h00, 8'h01);
        rd_chk(7'h0D, 8'h12);
        rd_chk(7'h2D, 8'h88);
        rd_chk(7'h00, 8'h01);
        `CHK("t1_mode", 1'b0, t1_mode)
        finish_test();
    end

    // the sequence needs about a thousand cycles; far more means a hang
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        finish_test();
    end
endmodule : e1_reset_defaults_config_bank_test
